// >>> ebsa_pkg.sv
// Constants and carrier types for the external bus strobe and acknowledge master.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
//
// Contract
// - The master asserts the transfer-begin strobe at the start of every external transfer.
// - In write-enable mode the lane strobes are asserted only during writes.
// - With the byte-lane mode bit set for a bank, lane strobes act as byte enables on reads and writes.
// - The master provides one write-enable strobe per byte lane for program operations.
// - The master drives the direction signal for every transaction to show read or write.
// - The master asserts one of four bank selects to target the addressed bank.
// - Output permit is asserted only for chip-select accesses; memories keep outputs off otherwise.
// - The master asserts burst-continue while it wants another beat after the current one; it also asserts it on multi-beat writes, which end after one beat.
package ebsa_pkg;
    localparam int EBSA_BANKS = 4;
    localparam int EBSA_LANES = 4;
    localparam int EBSA_ADDR_W = 32;
    localparam int EBSA_DATA_W = 32;
    localparam int EBSA_BEAT_W = 3;
    localparam int EBSA_FIFO_DEPTH = 16;
    localparam logic [EBSA_BANKS-1:0] EBSA_BANK_NONE = 4'hF;
    localparam logic [EBSA_LANES-1:0] EBSA_LANE_NONE = 4'hF;
    localparam logic [EBSA_BEAT_W-1:0] EBSA_BEAT_ZERO = 3'h0;
    localparam logic [EBSA_BEAT_W-1:0] EBSA_BEAT_ONE = 3'h1;
    localparam logic [EBSA_BEAT_W-1:0] EBSA_BEAT_TWO = 3'h2;
    localparam logic [EBSA_ADDR_W-1:0] EBSA_ADDR_STEP = 32'h4;

    typedef enum logic [1:0] {
        EBSA_IDLE,
        EBSA_START,
        EBSA_BEAT
    } ebsa_state_e;

    // One queued request
    typedef struct packed {
        logic write;
        logic [1:0] bank;
        logic [EBSA_LANES-1:0] lanes;
        logic [EBSA_BEAT_W-1:0] beats;
        logic [EBSA_ADDR_W-1:0] addr;
        logic [EBSA_DATA_W-1:0] wdata;
    } ebsa_req_s;

    // Pin-side outputs, strobes and enables active low; direction, address and data out are not
    typedef struct packed {
        logic ts_n;
        logic rd_wr;
        logic [EBSA_BANKS-1:0] cs_n;
        logic oe_n;
        logic [EBSA_LANES-1:0] lane_n;
        logic burst_continue_request_n;
        logic [EBSA_ADDR_W-1:0] addr;
        logic [EBSA_DATA_W-1:0] data_out;
        logic data_oe_n;
    } ebsa_pins_s;
endpackage

// >>> ebsa_fifo.sv
// Request FIFO of parameterised width and depth, flip-flop storage.
// Assumes writer and reader share the one clock.
`timescale 1ns/100ps
module ebsa_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } ebsa_fifo_s;

    ebsa_fifo_s st;
    ebsa_fifo_s next_st;
    logic push;
    logic pop;

    // Handshake flags
    assign in_ready = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and storage update
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop)
        begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// >>> ebsa_master.sv
// External bus master: strobe, selects, lane strobes and acknowledge handshake.
// Assumes the slave acknowledge arrives from a pin and is synchronised here.
`timescale 1ns/100ps
module ebsa_master
    import ebsa_pkg::*;
#(
    parameter int FIFO_DEPTH = EBSA_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request stream
    input wire logic req_valid,
    output logic req_ready,
    input wire ebsa_req_s req,
    // Per-bank lane mode, set selects byte enables
    input wire logic [EBSA_BANKS-1:0] byte_lane_mode_bit,
    // Read data return
    output logic rdata_valid,
    output logic [EBSA_DATA_W-1:0] rdata,
    output logic busy,
    // Bus pins
    output ebsa_pins_s pins,
    input wire logic slave_acknowledge_n,
    input wire logic [EBSA_DATA_W-1:0] data_in
);
    typedef struct packed {
        ebsa_state_e state;
        ebsa_req_s cur;
        logic [EBSA_BEAT_W-1:0] left;
        logic [1:0] ack_sync;
        logic [1:0][EBSA_DATA_W-1:0] din_sync;
        ebsa_pins_s pins;
        logic rdata_valid;
        logic [EBSA_DATA_W-1:0] rdata;
    } ebsa_master_s;

    ebsa_master_s st;
    ebsa_master_s next_st;
    logic q_valid;
    logic q_ready;
    ebsa_req_s q_data;
    logic ack;
    logic lane_on;

    ebsa_fifo #(.WIDTH($bits(ebsa_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clock(clock),
        .rst(rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    // Second synchroniser stage only
    assign ack = !st.ack_sync[1];
    assign q_ready = (st.state == EBSA_IDLE);
    assign pins = st.pins;
    assign rdata_valid = st.rdata_valid;
    assign rdata = st.rdata;
    assign busy = (st.state != EBSA_IDLE);

    // Lane strobe qualifier for the current request
    // writes always, reads only on a bank with its byte-lane mode bit set
    assign lane_on = st.cur.write || byte_lane_mode_bit[st.cur.bank];

    // Sequencer
    always_comb
    begin
        next_st = st;
        next_st.ack_sync = {st.ack_sync[0], slave_acknowledge_n};
        next_st.din_sync = {st.din_sync[0], data_in};
        next_st.rdata_valid = 1'b0;
        next_st.pins.ts_n = 1'b1;
        case (st.state)
            EBSA_IDLE:
            begin
                next_st.pins.cs_n = EBSA_BANK_NONE;
                next_st.pins.oe_n = 1'b1;
                next_st.pins.lane_n = EBSA_LANE_NONE;
                next_st.pins.burst_continue_request_n = 1'b1;
                next_st.pins.data_oe_n = 1'b1;
                if (q_valid)
                begin
                    next_st.cur = q_data;
                    next_st.left = (q_data.beats == EBSA_BEAT_ZERO) ? EBSA_BEAT_ONE : q_data.beats;
                    next_st.state = EBSA_START;
                end
            end
            EBSA_START:
            begin
                next_st.pins.ts_n = 1'b0;
                next_st.pins.rd_wr = !st.cur.write;
                next_st.pins.addr = st.cur.addr;
                next_st.pins.cs_n = ~(EBSA_BANKS'(1) << st.cur.bank);
                next_st.pins.oe_n = st.cur.write;
                next_st.pins.lane_n = lane_on ? ~st.cur.lanes : EBSA_LANE_NONE;
                next_st.pins.burst_continue_request_n = !(st.left > EBSA_BEAT_ONE);
                next_st.pins.data_out = st.cur.wdata;
                next_st.pins.data_oe_n = !st.cur.write;
                next_st.state = EBSA_BEAT;
            end
            EBSA_BEAT:
            begin
                if (ack)
                begin
                    if (!st.cur.write)
                    begin
                        next_st.rdata_valid = 1'b1;
                        next_st.rdata = st.din_sync[1];
                    end
                    if (st.cur.write || st.left == EBSA_BEAT_ONE)
                    begin
                        next_st.pins.cs_n = EBSA_BANK_NONE;
                        next_st.pins.oe_n = 1'b1;
                        next_st.pins.lane_n = EBSA_LANE_NONE;
                        next_st.pins.burst_continue_request_n = 1'b1;
                        next_st.pins.data_oe_n = 1'b1;
                        next_st.state = EBSA_IDLE;
                    end
                    else
                    begin
                        next_st.left = st.left - EBSA_BEAT_ONE;
                        next_st.pins.burst_continue_request_n = !(st.left > EBSA_BEAT_TWO);
                        next_st.pins.addr = st.pins.addr + EBSA_ADDR_STEP;
                    end
                end
            end
            default:
            begin
                next_st.state = EBSA_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= '0;
            st.state <= EBSA_IDLE;
            st.ack_sync <= 2'h3;
            st.pins.ts_n <= 1'b1;
            st.pins.rd_wr <= 1'b1;
            st.pins.cs_n <= EBSA_BANK_NONE;
            st.pins.oe_n <= 1'b1;
            st.pins.lane_n <= EBSA_LANE_NONE;
            st.pins.burst_continue_request_n <= 1'b1;
            st.pins.data_oe_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// >>> ebsa_sva.sv
// Checker on the bus master pins and the acknowledge path.
// Assumes it is bound into ebsa_master.
`timescale 1ns/100ps
module ebsa_sva
    import ebsa_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Watched ports
    input wire logic [EBSA_BANKS-1:0] byte_lane_mode_bit,
    input wire logic rdata_valid,
    input wire ebsa_pins_s pins,
    input wire logic slave_acknowledge_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Bank select and its lane mode
    wire logic sel = pins.cs_n != 4'hF;
    wire logic bmode = |(~pins.cs_n & byte_lane_mode_bit);
    // Start with a quiet acknowledge, and a read acknowledge
    sequence s_open;
        !pins.ts_n ##0 slave_acknowledge_n [*3];
    endsequence
    sequence s_read_ack;
        $fell(slave_acknowledge_n) && pins.rd_wr && sel;
    endsequence
    a_ts_one_cycle: assert property ($fell(pins.ts_n) |=> pins.ts_n)
        else $error("start strobe too long");
    a_bank_one_hot: assert property (!pins.ts_n |-> $onehot(~pins.cs_n))
        else $error("bank select not one hot");
    a_dir_oe_match: assert property (!pins.ts_n |-> pins.rd_wr == !pins.oe_n)
        else $error("direction and output permit differ");
    a_oe_only_sel: assert property (!pins.oe_n |-> sel)
        else $error("output permit without select");
    a_we_not_read: assert property (pins.rd_wr && pins.lane_n != 4'hF |-> bmode)
        else $error("write enable on a read");
    a_be_on_read: assert property (!pins.ts_n && pins.rd_wr && bmode |-> pins.lane_n != 4'hF)
        else $error("byte enables missing on read");
    a_we_on_write: assert property (!pins.ts_n && !pins.rd_wr |-> pins.lane_n != 4'hF)
        else $error("write enables missing");
    a_beat_held: assert property (s_open |-> sel)
        else $error("beat closed without acknowledge");
    a_ack_to_data: assert property (s_read_ack |-> ##[1:5] rdata_valid)
        else $error("read acknowledge gave no data");
endmodule
bind ebsa_master ebsa_sva u_sva (.*);

// >>> ebsa_slave.sv
// Behavioural slave: one acknowledge per read beat, one per write.
// Assumes the master registers its pins and synchronises the answer.
`timescale 1ns/100ps
module ebsa_slave
    import ebsa_pkg::*;
(
    // Clock, pins and acknowledge delay in cycles
    input wire logic clock,
    input wire ebsa_pins_s pins,
    input wire logic [7:0] delay,
    // Answers
    output logic slave_acknowledge_n,
    output logic [EBSA_DATA_W-1:0] data_in
);
    // Wait for a start, then answer beat by beat
    initial
    begin
        slave_acknowledge_n = 1'b1;
        data_in = 32'h0;
        forever
        begin
            @(posedge clock);
            #1;
            if (pins.ts_n === 1'b0)
            begin
                do
                begin
                    repeat (delay) @(posedge clock);
                    #1;
                    slave_acknowledge_n = 1'b0;
                    data_in = pins.oe_n ? ~data_in : pins.addr ^ 32'h5A5A0000;
                    @(posedge clock);
                    #1;
                    slave_acknowledge_n = 1'b1;
                    data_in = ~data_in;
                    repeat (2) @(posedge clock);
                    #1;
                end
                while (pins.rd_wr && pins.cs_n != 4'hF);
            end
        end
    end
endmodule

// >>> ebsa_tb.sv
// Bench: burst read, writes on every bank, FIFO fill and drain.
// Assumes the slave model answers the master.
`timescale 1ns/100ps
module testbench
    import ebsa_pkg::*;
();
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready, rdata_valid, busy, ack_n;
    logic [3:0] mode = 4'h0;
    logic [7:0] delay = 8'h1;
    logic [31:0] rdata, data_in;
    logic [31:0] rq[$];
    ebsa_req_s req = '0;
    ebsa_pins_s pins, snap;
    int mismatches = 0, comparisons = 0, starts = 0;
    // Clock
    always #25 clock = ~clock;
    // Master and slave
    ebsa_master DUT (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .byte_lane_mode_bit(mode), .rdata_valid(rdata_valid), .rdata(rdata),
        .busy(busy), .pins(pins), .slave_acknowledge_n(ack_n), .data_in(data_in));
    ebsa_slave u_slave (.clock(clock), .pins(pins), .delay(delay),
        .slave_acknowledge_n(ack_n), .data_in(data_in));
    // Record each start and each returned word, away from the launching edge
    always @(negedge clock)
    begin
        if (pins.ts_n === 1'b0)
        begin
            snap <= pins;
            starts <= starts + 1;
        end
        if (rdata_valid === 1'b1)
            rq.push_back(rdata);
    end
    task automatic check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Queue one request, then wait until the master is idle
    task automatic xfer(input logic wr, input logic [1:0] bank, input logic [3:0] lanes,
        input logic [2:0] beats);
        rq.delete();
        @(negedge clock);
        req = '{wr, bank, lanes, beats, 32'h1000, 32'hCAFE0000};
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        repeat (3) @(negedge clock);
        for (int n = 0; busy !== 1'b0 && n < 400; n++)
            @(negedge clock);
        // One more edge so the monitor has logged the last word
        @(negedge clock);
    endtask
    // Four beat read on bank two in byte lane mode
    task automatic t_burst();
        mode = 4'h4;
        xfer(1'b0, 2'd2, 4'hF, 3'd4);
        check("rd cs", snap.cs_n, 4'hB);
        check("rd dir oe", {snap.rd_wr, snap.oe_n}, 2'b10);
        check("rd lanes", snap.lane_n, 4'h0);
        check("rd burst_continue_request", snap.burst_continue_request_n, 1'b0);
        check("beats", rq.size(), 4);
        foreach (rq[i])
            check("rdata", rq[i], (32'h1000 + 4 * i) ^ 32'h5A5A0000);
        mode = 4'h0;
        // Single read in write-enable mode, zero beats count as one
        xfer(1'b0, 2'd0, 4'hF, 3'd0);
        check("we rd lanes", snap.lane_n, 4'hF);
        check("rd burst_continue_request one", snap.burst_continue_request_n, 1'b1);
        check("one beat", rq.size(), 1);
        check("rdata one", rq[0], 32'h1000 ^ 32'h5A5A0000);
    endtask
    // Write asking for two beats on every bank, one beat performed, lanes as write enables
    task automatic t_write();
        logic [3:0] e;
        for (int b = 0; b < 4; b++)
        begin
            e = ~(4'h1 << b);
            xfer(1'b1, b[1:0], 4'h3, 3'd2);
            check("wr cs", snap.cs_n, e);
            check("wr dir", {snap.rd_wr, snap.oe_n, snap.data_oe_n}, 3'b010);
            check("wr lanes", snap.lane_n, 4'hC);
            check("wr data", snap.data_out, 32'hCAFE0000);
            check("wr words", rq.size(), 0);
        end
    endtask
    // Slow slave: fill the queue until refused, then drain it
    task automatic t_fill();
        int n, s;
        n = 0;
        s = starts;
        delay = 8'd20;
        @(negedge clock);
        req = '{1'b1, 2'd3, 4'hF, 3'd1, 32'h1000, 32'h0};
        while (req_ready === 1'b1 && n < 40)
        begin
            req_valid = 1'b1;
            @(negedge clock);
            n++;
        end
        req_valid = 1'b0;
        check("fill", n >= 17 && n <= 18, 1'b1);
        delay = 8'd0;
        repeat (2000) if (starts < s + n) @(negedge clock);
        check("starts", starts - s, n);
    endtask
    initial
    begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        check("idle", {req_ready, pins.ts_n, pins.rd_wr, pins.cs_n, pins.lane_n}, 11'h7FF);
        t_burst();
        t_write();
        t_fill();
        end_of_test();
    end
    // Watchdog
    initial
    begin
        #1000000;
        mismatches++;
        end_of_test();
    end
endmodule
